// *** logic/cpucfg_clk_if.sv ***
// interface: clock-select handshake between config top and clock switcher
`timescale 1ns/10ps
interface cpucfg_clk_if;
   logic want_fast;
   logic sync_mode;
   logic on_fast;
   logic busy;
   modport ctl (output want_fast, output sync_mode, input on_fast, input busy);
   modport sw (input want_fast, input sync_mode, output on_fast, output busy);
endinterface

// *** logic/cpucfg_clk_switch.sv ***
// module: core clock selector with resync penalty in async mode
`timescale 1ns/10ps
module cpucfg_clk_switch #(
   parameter int MAX_PEN = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_fast_tick,
   input wire logic i_mem_tick,
   cpucfg_clk_if.sw ctl
);
   logic on_fast_q, on_fast_d;
   logic busy_q, busy_d;
   if (MAX_PEN < 1) begin : g_bad_pen
      $error("MAX_PEN must be at least 1");
   end
   always_comb begin
      on_fast_d = on_fast_q;
      busy_d = 1'b0;
      if (ctl.want_fast != on_fast_q) begin
         if (ctl.sync_mode) begin
            on_fast_d = ctl.want_fast;
         end else begin
            // wait for the destination clock's next tick: zero to one destination period
            busy_d = 1'b1;
            if (ctl.want_fast ? i_fast_tick : i_mem_tick) begin
               on_fast_d = ctl.want_fast;
               busy_d = 1'b0;
            end
         end
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         on_fast_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         on_fast_q <= on_fast_d;
         busy_q <= busy_d;
      end
   end
   assign ctl.on_fast = on_fast_q;
   assign ctl.busy = busy_q;
endmodule

// *** logic/cpucfg_pkg.sv ***
// package: constants, register map and mode encodings for core clocking and configuration
package cpucfg_pkg;
   localparam int CPUCFG_AW = 4;
   localparam int CPUCFG_DW = 32;
   localparam logic [3:0] CPUCFG_CTRL_OFS = 4'h0;
   localparam logic [3:0] CPUCFG_STAT_OFS = 4'h4;
   localparam logic [3:0] CPUCFG_MODE_OFS = 4'h8;
   localparam logic [3:0] CPUCFG_SWAP_OFS = 4'hc;
   localparam int CPUCFG_BIGEND_BIT = 0;
   localparam int CPUCFG_WPROG_BIT = 1;
   localparam int CPUCFG_WDATA_BIT = 2;
   localparam int CPUCFG_FASTREQ_BIT = 3;
   localparam logic [3:0] CPUCFG_CTRL_RST = 4'h0;
   localparam logic [4:0] CPUCFG_MODE_RST = 5'h13;
   localparam logic [4:0] CPUCFG_MODE_USR26 = 5'h00;
   localparam logic [4:0] CPUCFG_MODE_LEGACY_FAST_IRQ_MODE = 5'h01;
   localparam logic [4:0] CPUCFG_MODE_LEGACY_NORMAL_IRQ_MODE = 5'h02;
   localparam logic [4:0] CPUCFG_MODE_SVC26 = 5'h03;
   localparam int CPUCFG_NREGS = 31;
   localparam int CPUCFG_REG_W = 32;
   typedef enum logic [1:0] {
      CPUCFG_ADDR_26,
      CPUCFG_ADDR_26D32,
      CPUCFG_ADDR_32,
      CPUCFG_ADDR_BAD
   } cpucfg_space_e;
endpackage

// *** logic/cpucfg_top.sv ***
// top: core clocking and configuration control with register port
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module cpucfg_top #(
   parameter int CORE_DIV = 3
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // pins
   input wire logic i_memory_clock_input,
   input wire logic i_core_clock_input,
   input wire logic i_sync_async_strap,
   // core access request
   input wire logic i_acc_valid,
   input wire logic i_acc_cached,
   input wire logic i_acc_write,
   input wire logic i_acc_byte,
   input wire logic [31:0] i_acc_addr,
   input wire logic [31:0] i_acc_wdata,
   input wire logic [1:0] i_mode_req,
   input wire logic i_mode_set,
   input wire logic i_exception,
   // register port
   input wire logic [cpucfg_pkg::CPUCFG_AW-1:0] i_reg_addr,
   input wire logic [cpucfg_pkg::CPUCFG_DW-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [cpucfg_pkg::CPUCFG_DW-1:0] o_reg_rdata,
   // memory side
   output logic o_mem_valid,
   output logic o_mem_write,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   output logic [3:0] o_mem_lanes,
   output logic o_addr_exc,
   output logic o_core_on_fast,
   output logic o_switch_busy,
   output logic [4:0] o_cur_mode
);
   import cpucfg_pkg::*;

   if (CORE_DIV < 1) begin : g_bad_div
      $error("CORE_DIV must be at least 1");
   end

   // no coprocessor port: such work is left to software; access words match the core register width
   if (CPUCFG_REG_W != CPUCFG_DW) begin : g_bad_regw
      $error("register width must match the data bus");
   end

   // pin synchronisers
   logic [1:0] memory_clock_input_s_q, memory_clock_input_s_d;
   logic [1:0] corclk_s_q, corclk_s_d;
   logic [1:0] strap_s_q, strap_s_d;
   logic memory_clock_input_prev_q, memory_clock_input_prev_d;
   logic corclk_prev_q, corclk_prev_d;
   logic half_q, half_d;
   logic mem_tick, fast_tick;

   // rising edge of a synchronised pin
   function automatic logic rise_of(input logic cur, input logic prev);
      rise_of = cur && !prev;
   endfunction

   always_comb begin
      memory_clock_input_s_d = {memory_clock_input_s_q[0], i_memory_clock_input};
      corclk_s_d = {corclk_s_q[0], i_core_clock_input};
      strap_s_d = {strap_s_q[0], i_sync_async_strap};
      memory_clock_input_prev_d = memory_clock_input_s_q[1];
      corclk_prev_d = corclk_s_q[1];
      half_d = half_q;
      if (rise_of(memory_clock_input_s_q[1], memory_clock_input_prev_q)) begin
         half_d = ~half_q;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         memory_clock_input_s_q <= 2'h0;
         corclk_s_q <= 2'h0;
         strap_s_q <= 2'h0;
         memory_clock_input_prev_q <= 1'b0;
         corclk_prev_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         memory_clock_input_s_q <= memory_clock_input_s_d;
         corclk_s_q <= corclk_s_d;
         strap_s_q <= strap_s_d;
         memory_clock_input_prev_q <= memory_clock_input_prev_d;
         corclk_prev_q <= corclk_prev_d;
         half_q <= half_d;
      end
   end

   logic sync_mode;
   assign sync_mode = strap_s_q[1];
   // sync mode: fast ticks on every memory edge, memory side on every second one
   assign fast_tick = sync_mode ? rise_of(memory_clock_input_s_q[1], memory_clock_input_prev_q)
                                : rise_of(corclk_s_q[1], corclk_prev_q);
   assign mem_tick = rise_of(memory_clock_input_s_q[1], memory_clock_input_prev_q) && (!sync_mode || half_q);

   // clock selection
   cpucfg_clk_if clk_if ();
   // wanted clock is held after the access, since an async switch outlasts a one-cycle request
   logic want_q, want_d;
   always_comb begin
      want_d = want_q;
      if (i_acc_valid) begin
         want_d = i_acc_cached;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         want_q <= 1'b0;
      end else begin
         want_q <= want_d;
      end
   end
   assign clk_if.want_fast = want_d;
   assign clk_if.sync_mode = sync_mode;

   cpucfg_clk_switch #(
      .MAX_PEN(2)
   ) u_switch (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_fast_tick(fast_tick),
      .i_mem_tick(mem_tick),
      .ctl(clk_if)
   );

   // configuration register
   logic [3:0] ctrl_q, ctrl_d;
   logic [4:0] mode_q, mode_d;
   logic [CPUCFG_DW-1:0] rdata_q, rdata_d;
   logic [CPUCFG_DW-1:0] swap_q, swap_d;
   logic bigend, wprog, wdata;
   cpucfg_space_e space;

   assign bigend = ctrl_q[CPUCFG_BIGEND_BIT];
   assign wprog = ctrl_q[CPUCFG_WPROG_BIT];
   assign wdata = ctrl_q[CPUCFG_WDATA_BIT];

   function automatic cpucfg_space_e space_of(input logic p, input logic d);
      case ({p, d})
         2'b00: space_of = CPUCFG_ADDR_26;
         2'b01: space_of = CPUCFG_ADDR_26D32;
         2'b11: space_of = CPUCFG_ADDR_32;
         default: space_of = CPUCFG_ADDR_BAD;
      endcase
   endfunction

   // lane select for a byte within a word, per byte order
   function automatic logic [1:0] lane_of(input logic be, input logic [1:0] a);
      lane_of = be ? (2'h3 - a) : a;
   endfunction

   assign space = space_of(wprog, wdata);

   always_comb begin
      ctrl_d = ctrl_q;
      swap_d = swap_q;
      rdata_d = '0;
      if (i_reg_wr) begin
         case (i_reg_addr)
            CPUCFG_CTRL_OFS: ctrl_d = i_reg_wdata[3:0];
            CPUCFG_SWAP_OFS: swap_d = i_reg_wdata;
            default: ctrl_d = ctrl_q;
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            CPUCFG_CTRL_OFS: rdata_d = {28'h0, ctrl_q};
            CPUCFG_STAT_OFS: rdata_d = {26'h0, space, clk_if.busy, clk_if.on_fast, sync_mode, 1'b0};
            CPUCFG_MODE_OFS: rdata_d = {27'h0, mode_q};
            // byte order reorders load/store lanes and also byte-reverses the swap register on read
            CPUCFG_SWAP_OFS: rdata_d = bigend ? {swap_q[7:0], swap_q[15:8], swap_q[23:16], swap_q[31:24]}
                                              : swap_q;
            default: rdata_d = '0;
         endcase
      end
   end

   // operating mode: in 26-bit program space, mode sets and exceptions pick one of four legacy modes
   always_comb begin
      mode_d = mode_q;
      if (i_exception) begin
         mode_d = wprog ? CPUCFG_MODE_RST : CPUCFG_MODE_SVC26;
      end else if (i_mode_set) begin
         if (!wprog) begin
            mode_d = {3'h0, i_mode_req};
         end else begin
            mode_d = {3'h4, i_mode_req};
         end
      end
   end

   // memory access path; ctrl_q used, so a write lands before the next access
   logic mvalid_q, mvalid_d;
   logic mwrite_q, mwrite_d;
   logic [31:0] maddr_q, maddr_d;
   logic [31:0] mwdata_q, mwdata_d;
   logic [3:0] mlanes_q, mlanes_d;
   logic aexc_q, aexc_d;

   always_comb begin
      mvalid_d = i_acc_valid;
      mwrite_d = i_acc_write;
      maddr_d = i_acc_addr;
      mwdata_d = i_acc_wdata;
      mlanes_d = 4'hf;
      aexc_d = 1'b0;
      if (i_acc_valid) begin
         // address exceptions only in the narrow data space
         if (space == CPUCFG_ADDR_26 && i_acc_addr[31:26] != 6'h0) begin
            aexc_d = 1'b1;
            mvalid_d = 1'b0;
         end
         if (i_acc_byte) begin
            mlanes_d = 4'h1 << lane_of(bigend, i_acc_addr[1:0]);
            mwdata_d = {4{i_acc_wdata[7:0]}};
         end
      end else begin
         mvalid_d = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ctrl_q <= CPUCFG_CTRL_RST;
         swap_q <= '0;
         rdata_q <= '0;
         mode_q <= CPUCFG_MODE_RST;
         mvalid_q <= 1'b0;
         mwrite_q <= 1'b0;
         maddr_q <= '0;
         mwdata_q <= '0;
         mlanes_q <= 4'h0;
         aexc_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         swap_q <= swap_d;
         rdata_q <= rdata_d;
         mode_q <= mode_d;
         mvalid_q <= mvalid_d;
         mwrite_q <= mwrite_d;
         maddr_q <= maddr_d;
         mwdata_q <= mwdata_d;
         mlanes_q <= mlanes_d;
         aexc_q <= aexc_d;
      end
   end

   // outputs; clock state copied into flops so all outputs are registered
   logic onf_q, busy_o_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         onf_q <= 1'b0;
         busy_o_q <= 1'b0;
      end else begin
         onf_q <= clk_if.on_fast;
         busy_o_q <= clk_if.busy;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_mem_valid = mvalid_q;
   assign o_mem_write = mwrite_q;
   assign o_mem_addr = maddr_q;
   assign o_mem_wdata = mwdata_q;
   assign o_mem_lanes = mlanes_q;
   assign o_addr_exc = aexc_q;
   assign o_core_on_fast = onf_q;
   assign o_switch_busy = busy_o_q;
   assign o_cur_mode = mode_q;
endmodule

// *** sim/cpucfg_bench.sv ***
// bench: random and corner tests of the config block
`timescale 1ns/10ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module cpucfg_bench;
   import cpucfg_pkg::*;
   logic i_sys_clk = 0, i_srst = 1, i_memory_clock_input, i_core_clock_input, i_sync_async_strap = 1;
   logic i_acc_valid = 0, i_acc_cached = 0, i_acc_write = 1, i_acc_byte = 0, i_mode_set = 0, i_exception = 0;
   logic i_reg_wr = 0, i_reg_rd = 0, o_mem_valid, o_mem_write, o_addr_exc, o_core_on_fast, o_switch_busy, bt, x;
   logic [1:0] i_mode_req = 0;
   logic [3:0] i_reg_addr = 0, o_mem_lanes;
   logic [4:0] o_cur_mode;
   logic [31:0] i_acc_addr = 0, i_acc_wdata = 0, i_reg_wdata = 0, o_reg_rdata, o_mem_addr, o_mem_wdata, d, a;
   logic [2:0] cfg;
   int error_cnt = 0, checks_done = 0, k;
   cpucfg_top cpucfg_top_i (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_memory_clock_input(i_memory_clock_input),
      .i_core_clock_input(i_core_clock_input),
      .i_sync_async_strap(i_sync_async_strap),
      .i_acc_valid(i_acc_valid),
      .i_acc_cached(i_acc_cached),
      .i_acc_write(i_acc_write),
      .i_acc_byte(i_acc_byte),
      .i_acc_addr(i_acc_addr),
      .i_acc_wdata(i_acc_wdata),
      .i_mode_req(i_mode_req),
      .i_mode_set(i_mode_set),
      .i_exception(i_exception),
      .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata),
      .o_mem_valid(o_mem_valid),
      .o_mem_write(o_mem_write),
      .o_mem_addr(o_mem_addr),
      .o_mem_wdata(o_mem_wdata),
      .o_mem_lanes(o_mem_lanes),
      .o_addr_exc(o_addr_exc),
      .o_core_on_fast(o_core_on_fast),
      .o_switch_busy(o_switch_busy),
      .o_cur_mode(o_cur_mode)
   );
   cpucfg_mem_model cpucfg_mem_model_i (.i_strap(i_sync_async_strap), .o_mem_clk(i_memory_clock_input),
      .o_core_clk(i_core_clock_input));
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic rg(input logic w, input logic [3:0] ad, input logic [31:0] v);
      @(posedge i_sys_clk);
      i_reg_wr <= w;
      i_reg_rd <= !w;
      i_reg_addr <= ad;
      i_reg_wdata <= v;
      @(posedge i_sys_clk);
      i_reg_wr <= 0;
      i_reg_rd <= 0;
      #1 d = o_reg_rdata;
   endtask
   task automatic acc(input logic [31:0] ad, input logic b, input logic c);
      logic [31:0] wd;
      logic wr;
      wd = $urandom;
      wr = 1'($urandom);
      @(posedge i_sys_clk);
      i_acc_valid <= 1;
      i_acc_addr <= ad;
      i_acc_byte <= b;
      i_acc_cached <= c;
      i_acc_write <= wr;
      i_acc_wdata <= wd;
      @(posedge i_sys_clk);
      i_acc_valid <= 0;
      #1 x = !cfg[2] && !cfg[1] && |ad[31:26];
      `CK("exc", x, o_addr_exc)
      `CK("valid", !x, o_mem_valid)
      `CK("write", wr, o_mem_write)
      if (!x) `CK("wdata", b ? {4{wd[7:0]}} : wd, o_mem_wdata)
   endtask
   task automatic pl(input logic e, input logic [1:0] m);
      @(posedge i_sys_clk);
      i_exception <= e;
      i_mode_set <= 1;
      i_mode_req <= m;
      @(posedge i_sys_clk);
      i_exception <= 0;
      i_mode_set <= 0;
      #1;
   endtask
   task automatic sw(input logic c, input int lim);
      int n;
      int nb;
      n = 0;
      nb = 0;
      acc(0, 0, c);
      // busy must never show in sync mode, since switches there cost nothing
      while (o_core_on_fast !== c && n < 300) begin
         if (o_switch_busy === 1'b1) nb++;
         @(posedge i_sys_clk);
         #1 n++;
      end
      `CK("switch", 1'b1, n <= lim)
      `CK("sync_busy", 1'b0, i_sync_async_strap && nb != 0)
      `CK("busy_end", 1'b0, o_switch_busy)
      rg(0, CPUCFG_STAT_OFS, 0);
      `CK("stat", {c, i_sync_async_strap}, d[2:1])
   endtask
   initial begin
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #40000;
      error_cnt++;
      close_out;
   end
   initial begin
      void'($urandom(60091));
      cfg = 0;
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 0;
      rg(0, CPUCFG_CTRL_OFS, 0);
      `CK("ctrl_rst", 32'h0, d)
      `CK("mode_rst", CPUCFG_MODE_RST, o_cur_mode)
      rg(0, 4'h1, 0);
      `CK("unmapped", 32'h0, d)
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         k = $urandom % 3;
         cfg = {k == 0 ? 2'h0 : k == 1 ? 2'h2 : 2'h3, 1'($urandom)};
         rg(1, CPUCFG_CTRL_OFS, {29'h0, cfg});
         rg(0, CPUCFG_CTRL_OFS, 0);
         `CK("ctrl", {29'h0, cfg}, d)
         rg(0, CPUCFG_STAT_OFS, 0);
         `CK("space", 2'(k), d[5:4])
         a = $urandom;
         rg(1, CPUCFG_SWAP_OFS, a);
         rg(0, CPUCFG_SWAP_OFS, 0);
         `CK("swap", cfg[0] ? {a[7:0], a[15:8], a[23:16], a[31:24]} : a, d)
         repeat (4) begin
            a = $urandom;
            a[31:26] = $urandom % 2 ? a[31:26] : 6'h0;
            bt = 1'($urandom);
            acc(a, bt, 0);
            if (!x) `CK("addr", a, o_mem_addr)
            if (!x) `CK("lanes", !bt ? 4'hf : cfg[0] ? 4'h8 >> a[1:0] : 4'h1 << a[1:0], o_mem_lanes)
         end
         pl(1, 2'($urandom));
         `CK("exc_mode", cfg[1] ? CPUCFG_MODE_RST : CPUCFG_MODE_SVC26, o_cur_mode)
         for (int m = 0; m < 4; m++) begin
            pl(0, 2'(m));
            `CK("mode", cfg[1] ? {3'h4, 2'(m)} : 5'(m), o_cur_mode)
         end
      end
      cfg = 3'h4;
      rg(1, CPUCFG_CTRL_OFS, 32'h4);
      acc(32'hfc00_0000, 0, 0);
      cfg = 3'h0;
      rg(1, CPUCFG_CTRL_OFS, 32'h0);
      acc(32'h0400_0000, 0, 0);
      $display("test config done");
      sw(1, 3);
      sw(0, 3);
      i_sync_async_strap <= 0;
      repeat (4) @(posedge i_sys_clk);
      sw(1, 12);
      sw(0, 12);
      $display("test clock done");
      close_out;
   end
endmodule

// *** sim/cpucfg_mem_model.sv ***
// partner: memory side clock pins
`timescale 1ns/10ps
module cpucfg_mem_model (
   // strap seen by the board
   input wire logic i_strap,
   // clock pins
   output logic o_mem_clk,
   output logic o_core_clk
);
   initial begin
      o_mem_clk = 0;
      forever #13 o_mem_clk = ~o_mem_clk;
   end
   // core pin held low in sync mode, free and unrelated otherwise
   initial begin
      o_core_clk = 0;
      forever #7.3 o_core_clk = i_strap ? 1'b0 : ~o_core_clk;
   end
endmodule

// *** sim/cpucfg_props.sv ***
// checker: port properties of the config block
`timescale 1ns/10ps
module cpucfg_props import cpucfg_pkg::*; (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // inputs
   input wire logic i_sync_async_strap,
   input wire logic i_acc_valid,
   input wire logic i_acc_cached,
   input wire logic i_acc_byte,
   input wire logic [31:0] i_acc_addr,
   input wire logic [1:0] i_mode_req,
   input wire logic i_mode_set,
   input wire logic i_exception,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   // outputs
   input wire logic o_mem_valid,
   input wire logic [31:0] o_mem_addr,
   input wire logic [3:0] o_mem_lanes,
   input wire logic o_addr_exc,
   input wire logic o_core_on_fast,
   input wire logic [4:0] o_cur_mode
);
   logic [2:0] cfg_q;
   logic [2:0] cfg_d;
   logic bad;
   // shadow of the control bits, so checks follow software writes
   always_comb begin
      cfg_d = cfg_q;
      if (i_reg_wr && i_reg_addr == CPUCFG_CTRL_OFS) begin
         cfg_d = i_reg_wdata[2:0];
      end
   end
   always_ff @(posedge i_sys_clk) begin
      cfg_q <= i_srst ? 3'h0 : cfg_d;
   end
   assign bad = cfg_q[2:1] == 2'h0 && |i_acc_addr[31:26];
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   a_addr_pass:
   assert property (i_acc_valid && !bad |=> o_mem_valid && o_mem_addr == $past(i_acc_addr)) else $error("addr lost");
   a_exc_narrow:
   assert property (i_acc_valid && bad |=> o_addr_exc && !o_mem_valid) else $error("no addr exception");
   a_no_exc_wide:
   assert property (i_acc_valid && cfg_q[2] |=> !o_addr_exc) else $error("exception in wide data");
   a_lane_little:
   assert property (i_acc_valid && i_acc_byte && !bad && !cfg_q[0] |=> o_mem_lanes == 4'h1 << $past(i_acc_addr[1:0]))
      else $error("little lane wrong");
   a_lane_big:
   assert property (i_acc_valid && i_acc_byte && !bad && cfg_q[0] |=> o_mem_lanes == 4'h8 >> $past(i_acc_addr[1:0]))
      else $error("big lane wrong");
   a_exc_mode26:
   assert property (i_exception && !cfg_q[1] |=> o_cur_mode == CPUCFG_MODE_SVC26) else $error("bad 26-bit entry");
   a_mode_set26:
   assert property (i_mode_set && !i_exception && !cfg_q[1] |=> o_cur_mode == {3'h0, $past(i_mode_req)})
      else $error("legacy mode wrong");
   a_sync_fast:
   assert property (i_sync_async_strap && $past(i_sync_async_strap, 4) && i_acc_valid && i_acc_cached
      |-> ##[1:3] o_core_on_fast) else $error("sync switch slow");
endmodule
bind cpucfg_top cpucfg_props cpucfg_props_i (
   .i_sys_clk(i_sys_clk),
   .i_srst(i_srst),
   .i_sync_async_strap(i_sync_async_strap),
   .i_acc_valid(i_acc_valid),
   .i_acc_cached(i_acc_cached),
   .i_acc_byte(i_acc_byte),
   .i_acc_addr(i_acc_addr),
   .i_mode_req(i_mode_req),
   .i_mode_set(i_mode_set),
   .i_exception(i_exception),
   .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr),
   .o_mem_valid(o_mem_valid),
   .o_mem_addr(o_mem_addr),
   .o_mem_lanes(o_mem_lanes),
   .o_addr_exc(o_addr_exc),
   .o_core_on_fast(o_core_on_fast),
   .o_cur_mode(o_cur_mode)
);
